// File: hdl/atc_pkg.sv
// constants shared by the tilt/interrupt configuration register block
package atc_pkg;
  // =========================================================
  // register addresses (7-bit serial link address space)
  localparam logic [6:0] ADDR_STATUS  = 7'h14;
  localparam logic [6:0] ADDR_LINK    = 7'h31;
  localparam logic [6:0] ADDR_DRIVE   = 7'h33;
  localparam logic [6:0] ADDR_THR_LO  = 7'h40;
  localparam logic [6:0] ADDR_THR_HI  = 7'h41;
  // =========================================================
  // reset values and read masks
  localparam logic [7:0] RST_REG8     = 8'h00;
  localparam logic [7:0] LINK_RD_MASK = 8'hFC;
  localparam logic [7:0] RD_NONE      = 8'h00;
  localparam logic [7:0] CLR_ALL      = 8'hFF;
  // =========================================================
  // field positions
  localparam int LC_SWAP    = 4;
  localparam int LC_3WIRE   = 5;
  localparam int LC_INDIV   = 6;
  localparam int PD_P1_AH   = 2;
  localparam int PD_P1_PP   = 3;
  localparam int PD_P2_AH   = 6;
  localparam int PD_P2_PP   = 7;
  localparam int TILT35_BIT = 4;
  localparam int RD_FLAG    = 7;
  localparam int THR_HI_W   = 7;
  // =========================================================
  // widths and serial frame counts
  localparam int THR_W  = 15;
  localparam int STAT_W = 8;
  localparam logic [3:0] CNT_CMD_LAST  = 4'h7;
  localparam logic [3:0] CNT_DATA_LAST = 4'hF;
  // =========================================================
  // orientation result, one-hot
  typedef enum logic [2:0] {
    ORIENT_FLAT = 3'b001,
    ORIENT_TILT = 3'b010,
    ORIENT_FLIP = 3'b100
  } atc_orient_e;
endpackage

// File: hdl/atc_pin_drv.sv
// interrupt pin output stage: polarity and open-drain / push-pull drive
`timescale 1ns/1ns
module atc_pin_drv (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic req,
  input  wire logic active_high,
  input  wire logic push_pull,
  output logic      pin_out,
  output logic      pin_oe
);
  // =========================================================
  // level the pin should show, then how it is driven
  wire lvl        = req ~^ active_high;
  wire next_out   = push_pull ? lvl : 1'b0;    // open drain only ever drives low
  wire next_oe    = push_pull ? 1'b1 : ~lvl;   // open drain high comes from the pullup

  // registered so the pad never sees decode glitches
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end
endmodule // atc_pin_drv

// File: hdl/atc_link_regs.sv
// serial register block: link control, irq pin drive, tilt threshold and detector
//
// Operation
// - bits 1:0 of link control always read back as zero.
// - swap bit clear: group one drives pin one, group two pin two.
// - swap bit set: group one drives pin two, group two pin one.
// - three-wire bit set: serial out pin carries both data directions.
// - individual-clear off: any status write clears every pending interrupt.
// - individual-clear on: status write data is a per-bit clear mask.
// - drive bit 2 sets pin one active level, one means high.
// - drive bit 3 selects pin one open-drain or push-pull.
// - drive bit 6 sets pin two active level, one means high.
// - drive bit 7 selects pin two open-drain or push-pull.
// - 15-bit threshold split low/high; sample above it means tilt.
// - sample below threshold means flat or flip, chosen by Z sign and orientation.
// - tilt detection sets status bit 4.
`timescale 1ns/1ns
module atc_link_regs
  import atc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              spi_cs_b,
  input  wire logic              spi_sclk,
  input  wire logic              spi_din,
  input  wire logic              serial_out_addr_pin_in,
  output logic                   serial_out_addr_pin_out,
  output logic                   serial_out_addr_pin_oe,
  input  wire logic [STAT_W-1:0] event_set,
  input  wire logic              group_two_req,
  input  wire logic [THR_W-1:0]  sample_mag,
  input  wire logic              sample_valid,
  input  wire logic              sample_z_neg,
  input  wire logic              z_orient,
  output logic                   irq_pin_one_out,
  output logic                   irq_pin_one_oe,
  output logic                   irq_pin_two_out,
  output logic                   irq_pin_two_oe,
  output logic [STAT_W-1:0]      int_status,
  output atc_orient_e            orient_state
);
  // =========================================================
  // pin synchronisers: {cs_b, sclk, din, sdo_in}
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       sclk_d;

  // stage one is read only by stage two
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sync1  <= 4'h8;
      sync2  <= 4'h8;
      sclk_d <= 1'b0;
    end else begin
      sync1  <= {spi_cs_b, spi_sclk, spi_din, serial_out_addr_pin_in};
      sync2  <= sync1;
      sclk_d <= sync2[2];
    end
  end

  // =========================================================
  // registers
  logic [7:0]          link_ctrl;
  logic [7:0]          pin_drive;
  logic [7:0]          thr_lo;
  logic [THR_HI_W-1:0] thr_hi;

  wire three_wire = link_ctrl[LC_3WIRE];
  wire swap       = link_ctrl[LC_SWAP];
  wire indiv      = link_ctrl[LC_INDIV];
  wire [THR_W-1:0] tilt_threshold_value = {thr_hi, thr_lo};

  // =========================================================
  // serial frame decode, mode 0: sample on sclk rise, shift out on fall
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic       rd_cmd;
  logic [6:0] cmd_addr;
  logic [7:0] tx;

  wire frame      = ~sync2[3];
  wire sclk_rise  = sync2[2] & ~sclk_d;
  wire sclk_fall  = ~sync2[2] & sclk_d;
  wire mosi_bit   = three_wire ? sync2[0] : sync2[1];
  wire [7:0] rx_byte = {shift_in[6:0], mosi_bit};
  wire cmd_done   = frame & sclk_rise & (bit_cnt == CNT_CMD_LAST);
  wire data_done  = frame & sclk_rise & (bit_cnt == CNT_DATA_LAST);
  wire wr_stb     = data_done & ~rd_cmd;
  wire rd_active  = frame & rd_cmd & bit_cnt[3];

  // reserved low bits never leave the block on a read
  wire [6:0] rd_addr = rx_byte[6:0];
  wire [7:0] rd_data = (rd_addr == ADDR_LINK)   ? (link_ctrl & LINK_RD_MASK) :
                       (rd_addr == ADDR_STATUS) ? int_status : RD_NONE;

  // bit counter wraps after 16, so a held select runs back-to-back pairs
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !frame) begin
      bit_cnt  <= 4'h0;
      rd_cmd   <= 1'b0;
      shift_in <= RST_REG8;
      cmd_addr <= 7'h00;
    end else if (sclk_rise) begin
      bit_cnt  <= bit_cnt + 4'h1;
      shift_in <= rx_byte;
      if (cmd_done) begin
        rd_cmd   <= rx_byte[RD_FLAG];
        cmd_addr <= rd_addr;
      end
      if (data_done) rd_cmd <= 1'b0;
    end
  end

  // read data shifts out msb first; pin only driven during the data byte
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx                      <= RST_REG8;
      serial_out_addr_pin_out <= 1'b0;
      serial_out_addr_pin_oe  <= 1'b0;
    end else begin
      serial_out_addr_pin_oe <= rd_active;
      if (cmd_done) begin
        tx <= rd_data;
      end else if (sclk_fall && rd_active) begin
        serial_out_addr_pin_out <= tx[7];
        tx                      <= {tx[6:0], 1'b0};
      end
    end
  end

  // =========================================================
  // register writes; host keeps bits 2, 3, 7 of link control at zero
  wire wr_link   = wr_stb & (cmd_addr == ADDR_LINK);
  wire wr_drive  = wr_stb & (cmd_addr == ADDR_DRIVE);
  wire wr_thr_lo = wr_stb & (cmd_addr == ADDR_THR_LO);
  wire wr_thr_hi = wr_stb & (cmd_addr == ADDR_THR_HI);
  wire wr_status = wr_stb & (cmd_addr == ADDR_STATUS);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      link_ctrl <= RST_REG8;
      pin_drive <= RST_REG8;
      thr_lo    <= RST_REG8;
      thr_hi    <= RST_REG8[THR_HI_W-1:0];
    end else begin
      if (wr_link)   link_ctrl <= rx_byte;
      if (wr_drive)  pin_drive <= rx_byte;
      if (wr_thr_lo) thr_lo    <= rx_byte;
      if (wr_thr_hi) thr_hi    <= rx_byte[THR_HI_W-1:0];
    end
  end

  // =========================================================
  // tilt / flat / flip detector
  wire tilt_hit  = sample_valid & (sample_mag > tilt_threshold_value);
  wire flat_hit  = sample_valid & (sample_mag < tilt_threshold_value);
  wire flip_side = sample_z_neg ^ z_orient;
  // equal sample matches neither branch, so state holds
  wire atc_orient_e next_orient = tilt_hit ? ORIENT_TILT :
                                  flat_hit ? (flip_side ? ORIENT_FLIP : ORIENT_FLAT) :
                                  orient_state;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) orient_state <= ORIENT_FLAT;
    else        orient_state <= next_orient;
  end

  // =========================================================
  // interrupt status: set wins over a clear in the same cycle
  wire [STAT_W-1:0] tilt35_mask = {{(STAT_W-1){1'b0}}, 1'b1} << TILT35_BIT;
  wire [STAT_W-1:0] set_mask    = event_set | (tilt_hit ? tilt35_mask : RD_NONE);
  wire [STAT_W-1:0] clr_mask    = !wr_status ? RD_NONE :
                                  indiv      ? rx_byte : CLR_ALL;
  wire [STAT_W-1:0] next_status = (int_status & ~clr_mask) | set_mask;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) int_status <= RST_REG8;
    else        int_status <= next_status;
  end

  // =========================================================
  // request groups onto pins
  wire group_one = |int_status;
  wire req_one   = swap ? group_two_req : group_one;
  wire req_two   = swap ? group_one : group_two_req;

  // one output stage per pin, each with its own level and drive bits
  atc_pin_drv u_pin_one (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .req         (req_one),
    .active_high (pin_drive[PD_P1_AH]),
    .push_pull   (pin_drive[PD_P1_PP]),
    .pin_out     (irq_pin_one_out),
    .pin_oe      (irq_pin_one_oe)
  );
  atc_pin_drv u_pin_two (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .req         (req_two),
    .active_high (pin_drive[PD_P2_AH]),
    .push_pull   (pin_drive[PD_P2_PP]),
    .pin_out     (irq_pin_two_out),
    .pin_oe      (irq_pin_two_oe)
  );

  // =========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  wire pin1_lvl = irq_pin_one_oe ? irq_pin_one_out : 1'b1;

  property p_resv_read;
    cmd_done && rx_byte[RD_FLAG] && (rd_addr == ADDR_LINK) |=> tx[1:0] == 2'b00;
  endproperty
  a_resv_read: assert property (p_resv_read) else $error("link ctrl low bits not zero");
  property p_swap_off;
    !swap |=> ((pin1_lvl == $past(pin_drive[PD_P1_AH])) == $past(group_one));
  endproperty
  a_swap_off: assert property (p_swap_off) else $error("pin one not group one");
  property p_swap_on;
    swap |=> ((pin1_lvl == $past(pin_drive[PD_P1_AH])) == $past(group_two_req));
  endproperty
  a_swap_on: assert property (p_swap_on) else $error("pin one not group two");
  property p_three_wire;
    three_wire && frame && sclk_rise |=> shift_in[0] == $past(sync2[0]);
  endproperty
  a_three_wire: assert property (p_three_wire) else $error("3-wire input not sampled");
  property p_clr_all;
    wr_status && !indiv && (set_mask == RD_NONE) |=> int_status == RD_NONE;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("status not fully cleared");
  property p_clr_mask;
    wr_status && indiv |=> int_status == $past((int_status & ~rx_byte) | set_mask);
  endproperty
  a_clr_mask: assert property (p_clr_mask) else $error("masked clear wrong");
  property p_p1_level;
    pin_drive[PD_P1_PP] |=> irq_pin_one_oe &&
      (irq_pin_one_out == ($past(req_one) ~^ $past(pin_drive[PD_P1_AH])));
  endproperty
  a_p1_level: assert property (p_p1_level) else $error("pin one level wrong");
  property p_p1_od;
    !pin_drive[PD_P1_PP] |=> !irq_pin_one_out &&
      (irq_pin_one_oe == ($past(req_one) ^ $past(pin_drive[PD_P1_AH])));
  endproperty
  a_p1_od: assert property (p_p1_od) else $error("pin one open drain wrong");
  property p_p2_level;
    pin_drive[PD_P2_PP] |=> irq_pin_two_oe &&
      (irq_pin_two_out == ($past(req_two) ~^ $past(pin_drive[PD_P2_AH])));
  endproperty
  a_p2_level: assert property (p_p2_level) else $error("pin two level wrong");
  property p_p2_od;
    !pin_drive[PD_P2_PP] |=> !irq_pin_two_out &&
      (irq_pin_two_oe == ($past(req_two) ^ $past(pin_drive[PD_P2_AH])));
  endproperty
  a_p2_od: assert property (p_p2_od) else $error("pin two open drain wrong");
  property p_tilt;
    sample_valid && (sample_mag > {thr_hi, thr_lo}) |=> orient_state == ORIENT_TILT;
  endproperty
  a_tilt: assert property (p_tilt) else $error("tilt not detected");
  property p_flat_flip;
    flat_hit |=> orient_state == ($past(flip_side) ? ORIENT_FLIP : ORIENT_FLAT);
  endproperty
  a_flat_flip: assert property (p_flat_flip) else $error("flat/flip wrong");
  property p_tilt35;
    tilt_hit |=> int_status[TILT35_BIT];
  endproperty
  a_tilt35: assert property (p_tilt35) else $error("tilt-35 flag not set");
  property p_equal_hold;
    sample_valid && (sample_mag == tilt_threshold_value) |=> $stable(orient_state);
  endproperty
  a_equal_hold: assert property (p_equal_hold) else $error("equal sample moved state");

  c_read:  cover property (cmd_done && rx_byte[RD_FLAG] ##[1:200] data_done);
  c_swap:  cover property (swap && group_one);
  c_flip:  cover property (orient_state == ORIENT_FLIP);
  c_indiv: cover property (wr_status && indiv);
endmodule // atc_link_regs

// File: testbench/atc_host_model.sv
// serial host model: mode 0 frames of command and data byte, four- or three-wire
`timescale 1ns/1ns
module atc_host_model (
  input  wire logic sys_clk,
  input  wire logic three_wire,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  output logic      cs_b,
  output logic      sclk,
  output logic      din,
  output logic      pin_lvl
);
  logic host_en  = 1'b0;
  logic host_bit = 1'b0;
  logic idle_pat = 1'b0;
  // =========================================================
  // released lines toggle so a stale value can never pass for data
  assign pin_lvl = dev_oe ? dev_out : ((host_en && three_wire) ? host_bit : idle_pat);
  assign din     = (host_en && !three_wire) ? host_bit : idle_pat;
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
  end
  always @(negedge sys_clk) begin
    idle_pat <= ~idle_pat;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // =========================================================
  // one frame; half sclk period is 4 cycles, read bit taken just before the fall
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] frame;
    int          i;
    // link control bits 2, 3 and 7 always go out as zero
    frame = {cmd, (cmd == 8'h31) ? (wd & 8'h73) : wd};
    rd    = 8'h00;
    @(negedge sys_clk);
    cs_b    = 1'b0;
    host_en = 1'b1;
    wait_n(4);
    for (i = 15; i >= 0; i--) begin
      host_en  = !(cmd[7] && i < 8);
      host_bit = frame[i];
      wait_n(4);
      sclk = 1'b1;
      wait_n(3);
      if (i < 8) rd[i] = pin_lvl;
      wait_n(1);
      sclk = 1'b0;
    end
    host_en = 1'b0;
    wait_n(4);
    cs_b = 1'b1;
    wait_n(6);
  endtask
endmodule // atc_host_model

// File: testbench/tb.sv
// self-checking bench for the link, pin drive and tilt threshold register block
`timescale 1ns/1ns
module tb;
  import atc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        three_wire = 1'b0;
  logic [7:0]  event_set = 8'h00;
  logic        group_two_req = 1'b0;
  logic [14:0] sample_mag = 15'h0000;
  logic        sample_valid = 1'b0;
  logic        sample_z_neg = 1'b0;
  logic        z_orient = 1'b0;
  logic        cs_b, sclk, din, pin_lvl, so_out, so_oe;
  logic        p1_out, p1_oe, p2_out, p2_oe;
  logic [7:0]  int_status;
  atc_orient_e orient_state;
  int          n_fail = 0;
  int          checks = 0;
  logic [7:0]  dv [4] = '{8'h00, 8'h44, 8'h88, 8'hCC};
  logic [1:0]  p1_exp, p2_exp;
  always #25 sys_clk = ~sys_clk;
  atc_host_model u_host (.sys_clk(sys_clk), .three_wire(three_wire), .dev_out(so_out),
    .dev_oe(so_oe), .cs_b(cs_b), .sclk(sclk), .din(din), .pin_lvl(pin_lvl));
  atc_link_regs DUT (.sys_clk(sys_clk), .rst_b(rst_b), .spi_cs_b(cs_b), .spi_sclk(sclk),
    .spi_din(din), .serial_out_addr_pin_in(pin_lvl), .serial_out_addr_pin_out(so_out),
    .serial_out_addr_pin_oe(so_oe), .event_set(event_set), .group_two_req(group_two_req),
    .sample_mag(sample_mag), .sample_valid(sample_valid), .sample_z_neg(sample_z_neg),
    .z_orient(z_orient), .irq_pin_one_out(p1_out), .irq_pin_one_oe(p1_oe),
    .irq_pin_two_out(p2_out), .irq_pin_two_oe(p2_oe), .int_status(int_status),
    .orient_state(orient_state));
  // =========================================================
  // comparison, verdict and register access helpers
  task automatic chk(input string nm, input logic [14:0] seen, input logic [14:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    u_host.xfer({1'b0, a}, d, dummy);
  endtask
  task automatic rd(input string nm, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_host.xfer({1'b1, a}, 8'h00, v);
    chk(nm, {7'h00, v}, {7'h00, exp});
  endtask
  task automatic pulse(input logic [7:0] ev);
    @(negedge sys_clk);
    event_set = ev;
    @(negedge sys_clk);
    event_set = 8'h00;
    repeat (2) @(negedge sys_clk);
  endtask
  // one qualified sample, then the orientation two cycles on
  task automatic smp(input logic [14:0] m, input logic z, input logic o, input atc_orient_e e);
    @(negedge sys_clk);
    sample_mag   = m;
    sample_z_neg = z;
    z_orient     = o;
    sample_valid = 1'b1;
    @(negedge sys_clk);
    sample_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("orient", {12'h000, orient_state}, {12'h000, e});
  endtask
  // expected {out, oe}: open drain only ever pulls low
  function automatic logic [1:0] pin_exp(input logic req, input logic ah, input logic pp);
    logic lvl;
    lvl = req ~^ ah;
    return pp ? {lvl, 1'b1} : {1'b0, ~lvl};
  endfunction
  // =========================================================
  // watchdog well past the expected run of about 230 us
  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end
  // =========================================================
  // main sequence
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("status_rst", {7'h00, int_status}, 15'h0000);
    chk("orient_rst", {12'h000, orient_state}, {12'h000, ORIENT_FLAT});
    chk("pins_oe_rst", {13'h0000, p1_oe, p2_oe}, 15'h0000);
    rd("link_rst", ADDR_LINK, 8'h00);
    rd("drive_wo", ADDR_DRIVE, 8'h00);
    rd("unmapped", 7'h50, 8'h00);
    wr(ADDR_LINK, 8'h43);
    rd("link_rd", ADDR_LINK, 8'h40);
    pulse(8'hFF);
    wr(ADDR_STATUS, 8'h0F);
    rd("status_mask", ADDR_STATUS, 8'hF0);
    wr(ADDR_LINK, 8'h03);
    wr(ADDR_STATUS, 8'h00);
    chk("status_all", {7'h00, int_status}, 15'h0000);
    // group one pending, group two toggled; every polarity and drive mix, both routings
    pulse(8'h01);
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 4; k++) begin
        group_two_req = k[0];
        wr(ADDR_LINK, s[0] ? 8'h10 : 8'h00);
        wr(ADDR_DRIVE, dv[k]);
        repeat (3) @(negedge sys_clk);
        // swap off: pin one shows group one; swap on: pin one shows group two
        p1_exp = pin_exp(s[0] ? k[0] : 1'b1, dv[k][2], dv[k][3]);
        p2_exp = pin_exp(s[0] ? 1'b1 : k[0], dv[k][6], dv[k][7]);
        chk("pin_one", {13'h0000, p1_out, p1_oe}, {13'h0000, p1_exp});
        chk("pin_two", {13'h0000, p2_out, p2_oe}, {13'h0000, p2_exp});
      end
    end
    group_two_req = 1'b0;
    // threshold 0x1234; top bit of the high byte must be dropped
    wr(ADDR_THR_LO, 8'h34);
    wr(ADDR_THR_HI, 8'h92);
    wr(ADDR_STATUS, 8'h00);
    smp(15'h1235, 1'b0, 1'b0, ORIENT_TILT);
    chk("tilt35", {7'h00, int_status}, 15'h0010);
    smp(15'h1234, 1'b0, 1'b0, ORIENT_TILT);
    smp(15'h1233, 1'b0, 1'b0, ORIENT_FLAT);
    smp(15'h1233, 1'b1, 1'b0, ORIENT_FLIP);
    smp(15'h1234, 1'b0, 1'b0, ORIENT_FLIP);
    smp(15'h1233, 1'b1, 1'b1, ORIENT_FLAT);
    // three-wire: both directions over the one pin
    wr(ADDR_LINK, 8'h20);
    three_wire = 1'b1;
    rd("link_3w", ADDR_LINK, 8'h20);
    wr(ADDR_LINK, 8'h30);
    rd("link_3w_wr", ADDR_LINK, 8'h30);
    wrap_up();
  end
endmodule // tb
